// file: rtl/ppls_params.svh
`ifndef PPLS_PARAMS_SVH
`define PPLS_PARAMS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define PPLS_OFS_LOCKOUT      16'h30e1
`define PPLS_OFS_SPLIT_PORT   16'h3c48
`define PPLS_OFS_SPLIT_GLOBAL 16'h4141
`define PPLS_OFS_SEL_P5       16'h416e
`define PPLS_OFS_SEL_P6       16'h416f
`define PPLS_OFS_OC_STATUS    16'h30f0

// ****************************************************************
// reset values and field positions
// ****************************************************************
`define PPLS_RST_LOCKOUT      8'h0a
`define PPLS_RST_ZERO         8'h00
`define PPLS_RST_SEL          8'h00
`define PPLS_BIT_GLOBAL_EN    0
`define PPLS_BIT_PORT5        5
`define PPLS_BIT_PORT6        6

// ****************************************************************
// pin select codes
// ****************************************************************
`define PPLS_SEL_P5_A         8'h42
`define PPLS_SEL_P5_B         8'h05
`define PPLS_SEL_P6_A         8'h06
`define PPLS_SEL_P6_B         8'h04

// ****************************************************************
// timing
// ****************************************************************
`define PPLS_CLK_PERIOD_NS    40
`define PPLS_LOCKOUT_UNIT_NS  1000000
`define PPLS_NUM_PORTS        6

`endif

// file: rtl/ppls_pkg.sv
package ppls_pkg;

  // ****************************************************************
  // lockout state of one port
  // ****************************************************************
  typedef enum logic [1:0]
  {
    PPLS_OFF  = 2'b00,
    PPLS_LOCK = 2'b01,
    PPLS_ON   = 2'b10
  } ppls_lock_e;

  typedef logic [7:0] ppls_byte_t;

endpackage

// file: rtl/ppls_lockout.sv
`timescale 1ns/10ps
`include "ppls_params.svh"

module ppls_lockout
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ms_tick,
  input  wire logic [7:0] lockout_ms,
  input  wire logic       power_en,
  input  wire logic       pin_in,
  output      logic       pin_out,
  output      logic       pin_oe,
  output      logic       pin_pullup,
  output      logic       oc_detect
);

  ppls_pkg::ppls_lock_e state_q;
  ppls_pkg::ppls_lock_e state_d;
  logic [7:0]           cnt_q;
  logic [7:0]           cnt_d;
  logic                 pin_s1_q;
  logic                 pin_s2_q;
  logic                 oc_q;
  logic                 oc_d;

  // ****************************************************************
  // lockout state machine
  // ****************************************************************
  // lockout spans lockout_ms+1 ticks so the first partial ms never shortens it
  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      ppls_pkg::PPLS_OFF:
      begin
        cnt_d = 8'h00;
        if (power_en)
          state_d = ppls_pkg::PPLS_LOCK;
      end
      ppls_pkg::PPLS_LOCK:
      begin
        if (!power_en)
          state_d = ppls_pkg::PPLS_OFF;
        else if (ms_tick && cnt_q == lockout_ms)
          state_d = ppls_pkg::PPLS_ON;
        else if (ms_tick)
          cnt_d = cnt_q + 8'h01;
      end
      ppls_pkg::PPLS_ON:
      begin
        if (!power_en)
          state_d = ppls_pkg::PPLS_OFF;
      end
      default:
      begin
        state_d = ppls_pkg::PPLS_OFF;
      end
    endcase
  end

  // low on the pin counts only once lockout is over
  always_comb
  begin
    oc_d = (state_q == ppls_pkg::PPLS_ON) && !pin_s2_q;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_q  <= ppls_pkg::PPLS_OFF;
      cnt_q    <= 8'h00;
      pin_s1_q <= 1'b1;
      pin_s2_q <= 1'b1;
      oc_q     <= 1'b0;
    end
    else
    begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      pin_s1_q <= pin_in;
      pin_s2_q <= pin_s1_q;
      oc_q     <= oc_d;
    end
  end

  // ****************************************************************
  // pin drive
  // ****************************************************************
  // off: drive low, pull-up off to save power; on: open drain sense
  assign pin_oe     = (state_q == ppls_pkg::PPLS_OFF);
  assign pin_out    = 1'b0;
  assign pin_pullup = (state_q != ppls_pkg::PPLS_OFF);
  assign oc_detect  = oc_q;

  // ****************************************************************
  // assertions
  // ****************************************************************
  sequence power_rise;
    !power_en ##1 power_en;
  endsequence

  AST_OFF_DRIVES_LOW: assert property (@(posedge clk) disable iff (!rst_n)
    !$past(power_en) |-> pin_oe && !pin_out && !pin_pullup)
    else $error("pin not driven low while power off");

  AST_ON_RELEASES: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) && $past(power_en) |-> !pin_oe && pin_pullup)
    else $error("pin not released while power on");

  AST_ENTER_LOCK: assert property (@(posedge clk) disable iff (!rst_n)
    power_rise |=> state_q == ppls_pkg::PPLS_LOCK ##1 !oc_detect)
    else $error("lockout not entered after power on");

  AST_LOCK_IGNORES: assert property (@(posedge clk) disable iff (!rst_n)
    state_q != ppls_pkg::PPLS_ON |=> !oc_detect)
    else $error("overcurrent flagged during lockout");

  AST_LOCK_LENGTH: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ppls_pkg::PPLS_LOCK && state_d == ppls_pkg::PPLS_ON) |-> ms_tick && cnt_q == lockout_ms)
    else $error("lockout ended at wrong count");

  AST_OC_ON_LOW: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ppls_pkg::PPLS_ON && !pin_s2_q) |=> oc_detect)
    else $error("low pin not flagged as overcurrent");

endmodule // ppls_lockout

// file: rtl/ppls_top.sv
// Function
// - after power on, ignore overcurrent until the start lockout expires
// - lockout field is 8 bits, counted in whole milliseconds
// - lockout field resets to 0x0a, ten milliseconds
// - power off: drive pin low, pull-up off
// - power on: output driver off, pull-up on, open drain sensing
// - power on: low level on pin means overcurrent, poly fuse included
// - split only possible on downstream ports five and six
// - port pin keeps USB 2.0 power; reassigned GPIO drives USB 3.x power
// - no overcurrent sensing on the split power output
// - port5 uses GPIO66 or GPIO5; port6 uses GPIO6 or GPIO4
// - per-port enable: bit5 port5, bit6 port6, other bits reserved
// - global enable bit0, other bits reserved, resets to zero
`timescale 1ns/10ps
`include "ppls_params.svh"

module ppls_top
#(
  parameter int MS_CYCLES = `PPLS_LOCKOUT_UNIT_NS / `PPLS_CLK_PERIOD_NS
)
(
  input  wire logic       CLK_SYS,
  input  wire logic       RESET_N,
  input  wire logic [5:0] PORT_POWER_EN,
  input  wire logic [5:0] PORT_CTL_IN,
  output      logic [5:0] PORT_CTL_OUT,
  output      logic [5:0] PORT_CTL_OE,
  output      logic [5:0] PORT_CTL_PULLUP,
  output      logic [5:0] OVERCURRENT,
  input  wire logic       SS_POWER_EN_P5,
  input  wire logic       SS_POWER_EN_P6,
  output      logic       GPIO66_OUT,
  output      logic       GPIO66_OE,
  output      logic       GPIO6_OUT,
  output      logic       GPIO6_OE,
  output      logic       GPIO5_OUT,
  output      logic       GPIO5_OE,
  output      logic       GPIO4_OUT,
  output      logic       GPIO4_OE,
  input  wire logic [15:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  output      logic [7:0] REG_RDATA
);

  ppls_pkg::ppls_byte_t lockout_q;
  ppls_pkg::ppls_byte_t lockout_d;
  logic [1:0]           port_en_q;
  logic [1:0]           port_en_d;
  logic                 glob_q;
  logic                 glob_d;
  ppls_pkg::ppls_byte_t sel5_q;
  ppls_pkg::ppls_byte_t sel5_d;
  ppls_pkg::ppls_byte_t sel6_q;
  ppls_pkg::ppls_byte_t sel6_d;
  ppls_pkg::ppls_byte_t rdata_q;
  ppls_pkg::ppls_byte_t rdata_d;
  logic [14:0]          div_q;
  logic [14:0]          div_d;
  logic                 ms_tick;
  logic [1:0]           pick5;
  logic [1:0]           pick6;
  logic [3:0]           gpio_out_q;
  logic [3:0]           gpio_out_d;
  logic [3:0]           gpio_oe_q;
  logic [3:0]           gpio_oe_d;

  // ****************************************************************
  // select decode
  // ****************************************************************
  // returns {option B, option A}; any other code leaves the pin unclaimed
  function automatic logic [1:0] pick_pin(input logic [7:0] sel, input logic [7:0] code_a,
                                          input logic [7:0] code_b);
    pick_pin = {sel == code_b, sel == code_a};
  endfunction

  assign pick5 = pick_pin(sel5_q, `PPLS_SEL_P5_A, `PPLS_SEL_P5_B);
  assign pick6 = pick_pin(sel6_q, `PPLS_SEL_P6_A, `PPLS_SEL_P6_B);

  // ****************************************************************
  // millisecond divider
  // ****************************************************************
  // one shared divider; per-port counters then only count ticks
  always_comb
  begin
    ms_tick = (div_q == 15'(MS_CYCLES - 1));
    div_d   = ms_tick ? 15'h0000 : div_q + 15'h0001;
  end

  // ****************************************************************
  // register file
  // ****************************************************************
  // writes land one edge after the strobe; reserved bits are never stored
  always_comb
  begin
    lockout_d = lockout_q;
    port_en_d = port_en_q;
    glob_d    = glob_q;
    sel5_d    = sel5_q;
    sel6_d    = sel6_q;
    rdata_d   = rdata_q;
    if (REG_WR)
    begin
      if (REG_ADDR == `PPLS_OFS_LOCKOUT)
        lockout_d = REG_WDATA;
      else if (REG_ADDR == `PPLS_OFS_SPLIT_PORT)
        port_en_d = {REG_WDATA[`PPLS_BIT_PORT6], REG_WDATA[`PPLS_BIT_PORT5]};
      else if (REG_ADDR == `PPLS_OFS_SPLIT_GLOBAL)
        glob_d = REG_WDATA[`PPLS_BIT_GLOBAL_EN];
      else if (REG_ADDR == `PPLS_OFS_SEL_P5)
        sel5_d = REG_WDATA;
      else if (REG_ADDR == `PPLS_OFS_SEL_P6)
        sel6_d = REG_WDATA;
    end
    if (REG_RD)
    begin
      rdata_d = `PPLS_RST_ZERO;
      if (REG_ADDR == `PPLS_OFS_LOCKOUT)
        rdata_d = lockout_q;
      else if (REG_ADDR == `PPLS_OFS_SPLIT_PORT)
      begin
        rdata_d[`PPLS_BIT_PORT5] = port_en_q[0];
        rdata_d[`PPLS_BIT_PORT6] = port_en_q[1];
      end
      else if (REG_ADDR == `PPLS_OFS_SPLIT_GLOBAL)
        rdata_d[`PPLS_BIT_GLOBAL_EN] = glob_q;
      else if (REG_ADDR == `PPLS_OFS_SEL_P5)
        rdata_d = sel5_q;
      else if (REG_ADDR == `PPLS_OFS_SEL_P6)
        rdata_d = sel6_q;
      else if (REG_ADDR == `PPLS_OFS_OC_STATUS)
        rdata_d = {2'b00, OVERCURRENT};
    end
  end

  // ****************************************************************
  // split power outputs
  // ****************************************************************
  // order {GPIO4, GPIO5, GPIO6, GPIO66}; pins are drive only, nothing sampled back
  always_comb
  begin
    gpio_oe_d  = {4{glob_q}} & {port_en_q[1] & pick6[1], port_en_q[0] & pick5[1],
                                port_en_q[1] & pick6[0], port_en_q[0] & pick5[0]};
    gpio_out_d = gpio_oe_d & {SS_POWER_EN_P6, SS_POWER_EN_P5, SS_POWER_EN_P6, SS_POWER_EN_P5};
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RESET_N)
    begin
      lockout_q  <= `PPLS_RST_LOCKOUT;
      port_en_q  <= 2'b00;
      glob_q     <= 1'b0;
      sel5_q     <= `PPLS_RST_SEL;
      sel6_q     <= `PPLS_RST_SEL;
      rdata_q    <= `PPLS_RST_ZERO;
      div_q      <= 15'h0000;
      gpio_out_q <= 4'h0;
      gpio_oe_q  <= 4'h0;
    end
    else
    begin
      lockout_q  <= lockout_d;
      port_en_q  <= port_en_d;
      glob_q     <= glob_d;
      sel5_q     <= sel5_d;
      sel6_q     <= sel6_d;
      rdata_q    <= rdata_d;
      div_q      <= div_d;
      gpio_out_q <= gpio_out_d;
      gpio_oe_q  <= gpio_oe_d;
    end
  end

  assign REG_RDATA  = rdata_q;
  assign GPIO66_OUT = gpio_out_q[0];
  assign GPIO66_OE  = gpio_oe_q[0];
  assign GPIO6_OUT  = gpio_out_q[1];
  assign GPIO6_OE   = gpio_oe_q[1];
  assign GPIO5_OUT  = gpio_out_q[2];
  assign GPIO5_OE   = gpio_oe_q[2];
  assign GPIO4_OUT  = gpio_out_q[3];
  assign GPIO4_OE   = gpio_oe_q[3];

  // ****************************************************************
  // per-port power and sense
  // ****************************************************************
  // split ports keep this path unchanged for their USB 2.0 power
  genvar gi;
  generate
    for (gi = 0; gi < `PPLS_NUM_PORTS; gi++)
    begin : g_port
      ppls_lockout u_ppls_lockout
      (
        .clk        (CLK_SYS),
        .rst_n      (RESET_N),
        .ms_tick    (ms_tick),
        .lockout_ms (lockout_q),
        .power_en   (PORT_POWER_EN[gi]),
        .pin_in     (PORT_CTL_IN[gi]),
        .pin_out    (PORT_CTL_OUT[gi]),
        .pin_oe     (PORT_CTL_OE[gi]),
        .pin_pullup (PORT_CTL_PULLUP[gi]),
        .oc_detect  (OVERCURRENT[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // assertions
  // ****************************************************************
  AST_LOCKOUT_RESET: assert property (@(posedge CLK_SYS)
    $rose(RESET_N) |-> lockout_q == `PPLS_RST_LOCKOUT && !glob_q)
    else $error("lockout reset value wrong");

  AST_PORT_RSVD: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (REG_RD && REG_ADDR == `PPLS_OFS_SPLIT_PORT) |=> REG_RDATA[4:0] == 5'h00 && !REG_RDATA[7]
      && REG_RDATA[`PPLS_BIT_PORT5] == $past(port_en_q[0])
      && REG_RDATA[`PPLS_BIT_PORT6] == $past(port_en_q[1]))
    else $error("per-port enable readback wrong");

  AST_GLOBAL_RSVD: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (REG_RD && REG_ADDR == `PPLS_OFS_SPLIT_GLOBAL) |=> REG_RDATA[7:1] == 7'h00
      && REG_RDATA[0] == $past(glob_q))
    else $error("global enable readback wrong");

  AST_SPLIT_QUAL: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    !(glob_q && port_en_q[0] && (pick5 != 2'b00)) |=> !GPIO66_OE && !GPIO5_OE)
    else $error("split output active without full qualification");

endmodule // ppls_top

// file: tb/ppls_switch_model.sv
`timescale 1ns/10ps

module ppls_switch_model
(
  input  wire logic       clk,
  input  wire logic [5:0] pin_out,
  input  wire logic [5:0] pin_oe,
  input  wire logic [5:0] pin_pullup,
  input  wire logic [5:0] fault,
  output      logic [5:0] pin_level
);
  logic [5:0] float_q;

  // ****************************************************************
  // external power switch or poly fuse on each port pin
  // ****************************************************************
  // undriven pin walks, so a floating pin never passes for a steady level
  initial float_q = 6'h15;
  always @(posedge clk) float_q <= ~float_q;

  // chip drive wins, then the switch flag or blown fuse, then the pull-up
  // level follows at once: a fuse port has no power-on-to-good wait
  always_comb
  begin
    for (int i = 0; i < 6; i++)
    begin
      if (pin_oe[i] === 1'b1)
        pin_level[i] = pin_out[i];
      else if (fault[i] === 1'b1)
        pin_level[i] = 1'b0;
      else if (pin_pullup[i] === 1'b1)
        pin_level[i] = 1'b1;
      else
        pin_level[i] = float_q[i];
    end
  end
endmodule // ppls_switch_model

// file: tb/ppls_top_tb.sv
`timescale 1ns/10ps

`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin err_total++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end

module ppls_top_tb;
  localparam int MS = 10;
  typedef struct { string nm; logic [7:0] ex; } ppls_note_s;

  logic        clk_sys, reset_n, ss5, ss6, reg_wr, reg_rd, rd_seen_q;
  logic [5:0]  power_en, ctl_in, ctl_out, ctl_oe, ctl_pu, oc, fault;
  logic        g66o, g66e, g6o, g6e, g5o, g5e, g4o, g4e;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, lk;
  logic [7:0]  code [4] = '{8'h42, 8'h05, 8'h06, 8'h04};
  int          err_total, compares, cnt, k;
  ppls_note_s  notes [$];
  ppls_note_s  n;

  ppls_top #(.MS_CYCLES(MS)) u_ppls_top
  (
    .CLK_SYS(clk_sys), .RESET_N(reset_n), .PORT_POWER_EN(power_en), .PORT_CTL_IN(ctl_in),
    .PORT_CTL_OUT(ctl_out), .PORT_CTL_OE(ctl_oe), .PORT_CTL_PULLUP(ctl_pu), .OVERCURRENT(oc),
    .SS_POWER_EN_P5(ss5), .SS_POWER_EN_P6(ss6), .GPIO66_OUT(g66o), .GPIO66_OE(g66e),
    .GPIO6_OUT(g6o), .GPIO6_OE(g6e), .GPIO5_OUT(g5o), .GPIO5_OE(g5e), .GPIO4_OUT(g4o),
    .GPIO4_OE(g4e), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_RDATA(reg_rdata)
  );

  ppls_switch_model u_ppls_switch_model
  (
    .clk(clk_sys), .pin_out(ctl_out), .pin_oe(ctl_oe), .pin_pullup(ctl_pu),
    .fault(fault), .pin_level(ctl_in)
  );

  // ****************************************************************
  // clock, read monitor and watchdog
  // ****************************************************************
  initial clk_sys = 1'b0;
  always #20 clk_sys = ~clk_sys;

  // read data lands one edge after the strobe, so compare on the next fall
  always @(posedge clk_sys) rd_seen_q <= reg_rd;
  always @(negedge clk_sys)
  begin
    if (rd_seen_q === 1'b1)
    begin
      n = notes.pop_front();
      `CHK(n.nm, n.ex, reg_rdata)
    end
  end

  // whole run is under 130 cycles; this limit of 5000 cycles only catches a hang
  initial
  begin
    #(40 * 5000);
    err_total++;
    end_sim();
  end

  task automatic end_sim();
    if (err_total == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ****************************************************************
  // register bus tasks, driven on the falling edge
  // ****************************************************************
  task automatic reg_write(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask

  task automatic reg_read(input logic [15:0] a, input logic [7:0] ex, input string nm);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    notes.push_back('{nm, ex});
    @(negedge clk_sys);
    reg_rd = 1'b0;
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    void'($urandom(27));
    {reset_n, ss5, ss6, reg_wr, reg_rd} = '0;
    {power_en, fault, reg_addr, reg_wdata} = '0;
    err_total = 0;
    compares = 0;
    repeat (5) @(negedge clk_sys);
    `CHK("reset drive", 6'h3f, ctl_oe)
    `CHK("reset pullup", 6'h00, ctl_pu)
    reset_n = 1'b1;
    reg_read(16'h30e1, 8'h0a, "lockout reset");
    reg_read(16'h3c48, 8'h00, "port split reset");
    reg_read(16'h4141, 8'h00, "global reset");
    reg_read(16'h1234, 8'h00, "unmapped");
    reg_write(16'h3c48, 8'hff);
    reg_read(16'h3c48, 8'h60, "port split bits");
    reg_write(16'h4141, 8'hff);
    reg_read(16'h4141, 8'h01, "global bits");
    // short nonzero lockout keeps the run brief; zero is never written
    lk = 8'(1 + $urandom % 3);
    reg_write(16'h30e1, lk);
    reg_read(16'h30e1, lk, "lockout");
    k = $urandom % 6;
    fault = 6'h3f;
    power_en = 6'h01 << k;
    @(negedge clk_sys);
    `CHK("sense drive", 1'b0, ctl_oe[k])
    `CHK("sense pullup", 1'b1, ctl_pu[k])
    cnt = 0;
    while (oc[k] !== 1'b1 && cnt < 400)
    begin
      @(negedge clk_sys);
      cnt++;
    end
    `CHK("lockout span", 1'b1, (cnt >= lk * MS && cnt <= (lk + 1) * MS + 4))
    `CHK("unpowered flag", 6'h00, oc & ~power_en)
    // fault still present, so the status bit stands while it is read
    reg_read(16'h30f0, 8'(6'h01 << k), "oc status");
    fault = 6'h00;
    repeat (2) @(negedge clk_sys);
    `CHK("flag latency", 1'b1, oc[k])
    @(negedge clk_sys);
    `CHK("flag clear", 1'b0, oc[k])
    power_en = 6'h00;
    @(negedge clk_sys);
    `CHK("off drive", 6'h3f, ctl_oe)
    `CHK("off pullup", 6'h00, ctl_pu)
    `CHK("drive level", 6'h00, ctl_out)
    reg_write(16'h3c48, 8'h60);
    // split ports keep their USB 2.0 power on through the split tests
    power_en = 6'h30;
    // every pin option of both split ports, one at a time
    for (int i = 0; i < 4; i++)
    begin
      ss5 = 1'($urandom);
      ss6 = 1'($urandom);
      reg_write(16'h416e, (i < 2) ? code[i] : 8'h00);
      reg_write(16'h416f, (i >= 2) ? code[i] : 8'h00);
      reg_write(16'h4141, 8'h01);
      @(negedge clk_sys);
      `CHK("split oe", 4'(4'b1000 >> i), {g66e, g5e, g6e, g4e})
      `CHK("split out", 4'(4'b1000 >> i) & {ss5, ss5, ss6, ss6}, {g66o, g5o, g6o, g4o})
      `CHK("port pins kept", 6'h0f, ctl_oe)
      `CHK("port pullups kept", 6'h30, ctl_pu)
      `CHK("split no sense", 6'h00, oc)
      reg_write(16'h4141, 8'h00);
      @(negedge clk_sys);
      `CHK("global off", 4'h0, {g66e, g5e, g6e, g4e})
    end
    // swapped codes are not valid selects for either port
    reg_write(16'h416e, 8'h06);
    reg_write(16'h416f, 8'h05);
    reg_write(16'h4141, 8'h01);
    @(negedge clk_sys);
    `CHK("bad select", 4'h0, {g66e, g5e, g6e, g4e})
    repeat (2) @(negedge clk_sys);
    end_sim();
  end
endmodule // ppls_top_tb
